//--- verilog/quad_dac_pkg.sv
// Constants, command codes and carrier types of the quad DAC control core
package quad_dac_pkg;

    // Sizes of the datapath
    localparam int NUM_CHANNELS = 4;
    localparam int CODE_W = 16;
    localparam int SPAN_W = 3;
    localparam int MUX_SEL_W = 5;
    localparam int SHIFT_W = 32;
    localparam int DECODE_W = 24;

    // Command codes carried in the top nibble of the decoded 24-bit word
    localparam logic [3:0] CMD_WRITE_N = 4'h0;
    localparam logic [3:0] CMD_UPDATE_N = 4'h1;
    localparam logic [3:0] CMD_WRITE_N_UPDATE_ALL = 4'h2;
    localparam logic [3:0] CMD_WRITE_N_UPDATE_N = 4'h3;
    localparam logic [3:0] CMD_POWER_DOWN_N = 4'h4;
    localparam logic [3:0] CMD_POWER_DOWN_CHIP = 4'h5;
    localparam logic [3:0] CMD_SPAN_N = 4'h6;
    localparam logic [3:0] CMD_CONFIG = 4'h7;
    localparam logic [3:0] CMD_WRITE_ALL = 4'h8;
    localparam logic [3:0] CMD_UPDATE_ALL = 4'h9;
    localparam logic [3:0] CMD_WRITE_ALL_UPDATE_ALL = 4'hA;
    localparam logic [3:0] CMD_MUX = 4'hB;
    localparam logic [3:0] CMD_TOGGLE_SEL = 4'hC;
    localparam logic [3:0] CMD_WRITE_B_N = 4'hD;
    localparam logic [3:0] CMD_SPAN_ALL = 4'hE;

    // Field positions inside the data field of control commands
    localparam int CFG_REF_DISABLE_POS = 0;
    localparam int MUX_ENABLE_POS = 5;

    // Output spans and reset codes
    localparam logic [2:0] SPAN_0_5 = 3'h0;
    localparam logic [2:0] SPAN_BIPOLAR_MIN = 3'h2;
    localparam logic [2:0] SPAN_MAX = 3'h4;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;

    // Highest monitor source: 4 outputs, 4 aux, ref low, ref, two rails, temperature
    localparam logic [4:0] MUX_SEL_MAX = 5'h0C;

    // Pin synchroniser lanes and their idle levels
    localparam int SYNC_W = 9;
    localparam int LANE_STROBE = 0;
    localparam int LANE_UPDATE = 1;
    localparam int LANE_TOGGLE = 2;
    localparam int LANE_CLEAR = 3;
    localparam int LANE_HOT = 4;
    localparam int LANE_REF_COMP_PIN = 5;
    localparam int LANE_STRAP = 6;
    localparam logic [8:0] SYNC_RESET = 9'h02B;

    // Core cycles after reset before straps are trusted
    localparam logic [1:0] START_CYCLES = 2'h3;

    // Serial word as decoded from the last 24 bits of a frame
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [15:0] data;
    } cmdWord_t;

    // State presented to one analog channel
    typedef struct packed {
        logic [15:0] code;
        logic [2:0] span;
        logic powered;
    } dacOut_t;

endpackage : quad_dac_pkg

//--- verilog/quad_dac_serial_control.sv
// Serial command decoder and channel register control of the quad DAC
//
// Contract
// - Update input falling with strobe high copies all input registers to DAC registers.
// - Update input falling with strobe low defers the copy until strobe rises.
// - Update input low powers channels up and blocks software power-down.
// - Host frames transfers with strobe low; only then does SCK shift SDI.
// - Strobe rising stops shifting and executes the command held in the register.
// - SDI is valid at, and captured on, each SCK rising edge.
// - Frames of 24 or 32 bits are both accepted.
// - SDO is the 32-bit register output, shown on falling SCK after 32 rises.
// - SDO floats whenever the strobe is high.
// - Toggle pin falling loads selected DAC registers from input register A.
// - Toggle pin rising loads selected DAC registers from input register B.
// - Toggle actions touch only channels whose toggle select bit is one.
// - Clear low holds every channel at strap reset code and span.
// - Clear low also forces all control register contents to zero.
// - Over-temperature flag pulls low once the die exceeds 160 degrees C.
// - Over-temperature flag stays low until the next strobe rising edge.
// - Span straps select power-on span and reset code for all channels.
// - Monitor mux routes outputs, aux inputs, references, rails or temperature.
// - Disabled monitor mux leaves its output high impedance.
// - Internal reference drives the reference pin by default.
// - Disabled internal reference disconnects, leaving the pin as an input.
// - Grounded compensation pin brings the part up with reference disabled.
// - Power-up resets all channel outputs to strap span and code.
`timescale 1ns/1ps

module quad_dac_serial_control
    import quad_dac_pkg::*;
#(
    parameter int NUM_CH = NUM_CHANNELS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdi,
    input wire logic select_load_n,
    output logic sdo,
    output logic sdoOe,
    input wire logic async_update_n,
    input wire logic toggle_pin,
    input wire logic clear_n,
    input wire logic overTempDetect,
    output logic overtemp_flag_n,
    output logic overtempFlagOe,
    input wire logic [2:0] span_strap_pins,
    input wire logic ref_comp_pin,
    output logic refDriveEnable,
    output logic [MUX_SEL_W-1:0] muxSel,
    output logic muxOutEnable,
    output dacOut_t [NUM_CH-1:0] chanOut
);

    // Addresses are one nibble and the toggle field four bits wide
    initial begin
        if (NUM_CH < 1 || NUM_CH > 4) begin
            $error("NUM_CH must lie between 1 and 4");
        end
    end

    // One-hot channel match for addressed commands
    function automatic logic [NUM_CH-1:0] chanMatch(input logic [3:0] addr);
        logic [NUM_CH-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            r[i] = (addr == 4'(i));
        end
        return r;
    endfunction : chanMatch

    // Strap decode: spans above the top code fall back to the smallest span
    function automatic logic [2:0] strapSpan(input logic [2:0] strap);
        return (strap > SPAN_MAX) ? SPAN_0_5 : strap;
    endfunction : strapSpan

    // Bipolar spans reset to mid-scale so the output rests at zero volts
    function automatic logic [15:0] strapCode(input logic [2:0] strap);
        return (strapSpan(strap) >= SPAN_BIPOLAR_MIN) ? CODE_MID : CODE_ZERO;
    endfunction : strapCode

    // ---------------- SCK domain ----------------
    logic [SHIFT_W-1:0] shiftReg;
    logic sdoBit;

    // Shift only inside a strobe-low frame, sampling SDI on the rising edge
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            shiftReg <= '0;
        end else if (!select_load_n) begin
            shiftReg <= {shiftReg[SHIFT_W-2:0], sdi};
        end
    end

    // Echo the register's top bit on the falling edge for readback and chaining
    always_ff @(negedge sck or posedge rst) begin
        if (rst) begin
            sdoBit <= 1'b0;
        end else if (!select_load_n) begin
            sdoBit <= shiftReg[SHIFT_W-1];
        end
    end

    assign sdo = sdoBit;
    assign sdoOe = !select_load_n;

    // ---------------- Core domain ----------------
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    logic [SYNC_W-1:0] syncPrev;
    logic [1:0] startCount;
    logic startLoad;
    logic strobeHigh;
    logic strobeRise;
    logic updateLow;
    logic updateFall;
    logic toggleFall;
    logic toggleRise;
    logic clearActive;
    logic [2:0] strapHeld;
    cmdWord_t word;

    // Two-stage synchronisers on every pin read by core logic
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncA <= SYNC_RESET;
            syncB <= SYNC_RESET;
            syncPrev <= SYNC_RESET;
        end else begin
            syncA <= {span_strap_pins, ref_comp_pin, overTempDetect, clear_n,
                      toggle_pin, async_update_n, select_load_n};
            syncB <= syncA;
            syncPrev <= syncB;
        end
    end

    // Edges are taken between second and third stage only
    assign strobeHigh = syncB[LANE_STROBE];
    assign strobeRise = syncB[LANE_STROBE] & ~syncPrev[LANE_STROBE];
    assign updateLow = ~syncB[LANE_UPDATE];
    assign updateFall = ~syncB[LANE_UPDATE] & syncPrev[LANE_UPDATE];
    assign toggleFall = ~syncB[LANE_TOGGLE] & syncPrev[LANE_TOGGLE];
    assign toggleRise = syncB[LANE_TOGGLE] & ~syncPrev[LANE_TOGGLE];
    assign clearActive = ~syncB[LANE_CLEAR];

    // The shift register is quiet while the strobe is high, so at the
    // synchronised rise, two core cycles after the pin rise, its word is stable to read
    assign word = cmdWord_t'(shiftReg[DECODE_W-1:0]);

    // Wait for the synchronisers to fill, then take the straps once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            startCount <= '0;
        end else if (startCount != START_CYCLES) begin
            startCount <= startCount + 2'h1;
        end
    end

    assign startLoad = (startCount == START_CYCLES - 2'h1);

    // Straps are fixed levels; keep them for later clears
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strapHeld <= '0;
        end else if (startLoad) begin
            strapHeld <= syncB[LANE_STRAP +: 3];
        end
    end

    // Per-channel strobes derived from the executed command
    logic [NUM_CH-1:0] writeA;
    logic [NUM_CH-1:0] writeB;
    logic [NUM_CH-1:0] writeSpan;
    logic [NUM_CH-1:0] swUpdate;
    logic [NUM_CH-1:0] swPowerDown;
    logic chipDownCmd;

    always_comb begin
        writeA = '0;
        writeB = '0;
        writeSpan = '0;
        swUpdate = '0;
        swPowerDown = '0;
        chipDownCmd = 1'b0;
        if (strobeRise) begin
            case (word.cmd)
                CMD_WRITE_N: writeA = chanMatch(word.addr);
                CMD_WRITE_ALL: writeA = '1;
                CMD_WRITE_B_N: writeB = chanMatch(word.addr);
                CMD_SPAN_N: writeSpan = chanMatch(word.addr);
                CMD_SPAN_ALL: writeSpan = '1;
                CMD_UPDATE_N: swUpdate = chanMatch(word.addr);
                CMD_UPDATE_ALL: swUpdate = '1;
                CMD_WRITE_N_UPDATE_N: begin
                    writeA = chanMatch(word.addr);
                    swUpdate = chanMatch(word.addr);
                end
                CMD_WRITE_N_UPDATE_ALL: begin
                    writeA = chanMatch(word.addr);
                    swUpdate = '1;
                end
                CMD_WRITE_ALL_UPDATE_ALL: begin
                    writeA = '1;
                    swUpdate = '1;
                end
                CMD_POWER_DOWN_N: swPowerDown = chanMatch(word.addr);
                CMD_POWER_DOWN_CHIP: begin
                    swPowerDown = '1;
                    chipDownCmd = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // Update input falling: act now if strobe high, otherwise hold for the rise
    logic updatePending;
    logic hwUpdate;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            updatePending <= 1'b0;
        end else if (updateFall && !strobeHigh) begin
            updatePending <= 1'b1;
        end else if (strobeRise) begin
            updatePending <= 1'b0;
        end
    end

    assign hwUpdate = (updateFall && strobeHigh) || (strobeRise && updatePending);

    // Control registers: toggle select, monitor mux, reference and chip power
    logic [NUM_CH-1:0] toggleSel;
    logic refDisable;
    logic muxEnable;
    logic [MUX_SEL_W-1:0] muxSource;
    logic chipDown;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            toggleSel <= '0;
            refDisable <= 1'b0;
            muxEnable <= 1'b0;
            muxSource <= '0;
            chipDown <= 1'b0;
        end else if (startLoad) begin
            refDisable <= ~syncB[LANE_REF_COMP_PIN];
        end else if (clearActive) begin
            toggleSel <= '0;
            refDisable <= 1'b0;
            muxEnable <= 1'b0;
            muxSource <= '0;
            chipDown <= 1'b0;
        end else begin
            if (strobeRise && word.cmd == CMD_TOGGLE_SEL) begin
                toggleSel <= word.data[NUM_CH-1:0];
            end
            if (strobeRise && word.cmd == CMD_CONFIG) begin
                refDisable <= word.data[CFG_REF_DISABLE_POS];
            end
            // Out-of-range sources are refused and the old choice kept
            if (strobeRise && word.cmd == CMD_MUX && word.data[4:0] <= MUX_SEL_MAX) begin
                muxEnable <= word.data[MUX_ENABLE_POS];
                muxSource <= word.data[4:0];
            end
            // Chip power-down loses to a held-low update input
            if (updateLow || hwUpdate || swUpdate != '0) begin
                chipDown <= 1'b0;
            end else if (chipDownCmd) begin
                chipDown <= 1'b1;
            end
        end
    end

    assign refDriveEnable = ~refDisable & ~chipDown;
    assign muxSel = muxSource;
    assign muxOutEnable = muxEnable & ~chipDown;

    // Channel registers: input A and B, DAC register, span and power state
    logic [CODE_W-1:0] inputA [NUM_CH];
    logic [CODE_W-1:0] inputB [NUM_CH];
    logic [CODE_W-1:0] dacReg [NUM_CH];
    logic [SPAN_W-1:0] spanReg [NUM_CH];
    logic [NUM_CH-1:0] powered;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                inputA[i] <= '0;
                inputB[i] <= '0;
                dacReg[i] <= '0;
                spanReg[i] <= '0;
            end
            powered <= '0;
        end else if (startLoad) begin
            for (int i = 0; i < NUM_CH; i++) begin
                inputA[i] <= strapCode(syncB[LANE_STRAP +: 3]);
                inputB[i] <= strapCode(syncB[LANE_STRAP +: 3]);
                dacReg[i] <= strapCode(syncB[LANE_STRAP +: 3]);
                spanReg[i] <= strapSpan(syncB[LANE_STRAP +: 3]);
            end
        end else if (clearActive) begin
            // Level clear holds channels at reset while low
            for (int i = 0; i < NUM_CH; i++) begin
                inputA[i] <= strapCode(strapHeld);
                inputB[i] <= strapCode(strapHeld);
                dacReg[i] <= strapCode(strapHeld);
                spanReg[i] <= strapSpan(strapHeld);
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (writeA[i]) begin
                    inputA[i] <= word.data;
                end
                if (writeB[i]) begin
                    inputB[i] <= word.data;
                end
                if (writeSpan[i] && word.data[2:0] <= SPAN_MAX) begin
                    spanReg[i] <= word.data[2:0];
                end
                // Updates take this cycle's write, so write-and-update and a
                // deferred update both land the newly written code
                if (hwUpdate || swUpdate[i]) begin
                    dacReg[i] <= writeA[i] ? word.data : inputA[i];
                end else if (toggleFall && toggleSel[i]) begin
                    dacReg[i] <= inputA[i];
                end else if (toggleRise && toggleSel[i]) begin
                    dacReg[i] <= inputB[i];
                end
                if (updateLow || hwUpdate || swUpdate[i]) begin
                    powered[i] <= 1'b1;
                end else if (swPowerDown[i]) begin
                    powered[i] <= 1'b0;
                end
            end
        end
    end

    // Present channel state to the analog side
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            chanOut[i] = '{code: dacReg[i], span: spanReg[i], powered: powered[i]};
        end
    end

    // Over-temperature flag: a new detection beats the strobe release
    logic overFlag;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            overFlag <= 1'b0;
        end else if (syncB[LANE_HOT]) begin
            overFlag <= 1'b1;
        end else if (strobeRise) begin
            overFlag <= 1'b0;
        end
    end

    // Open-drain: drives low only while flagged
    assign overtemp_flag_n = 1'b0;
    assign overtempFlagOe = overFlag;

endmodule : quad_dac_serial_control

//--- verification/host_link_model.sv
// Host side of the serial link: frames words on sck, sdi and the strobe
`timescale 1ns/1ps

module host_link_model (
    output logic sck,
    output logic sdi,
    output logic select_load_n,
    input wire logic sdoLine
);
    logic [31:0] echo;

    // Idle levels at time zero; the link clock stands low outside frames
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        select_load_n = 1'b1;
        echo = 32'h0;
    end

    // One frame of n bits, MSB first, 80 ns link clock period
    task frame(input logic [31:0] w, input int n);
        #7 select_load_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= w[i];
            // Echo taken just before the rise, where the last fall's bit stands
            #20 echo = {echo[30:0], sdoLine};
            sck <= 1'b1;
            #40 sck <= 1'b0;
            #20;
        end
        #13 select_load_n <= 1'b1;
        sdi <= ~sdi; // Released line must not keep showing the last bit
        #60;
    endtask : frame
endmodule : host_link_model

//--- verification/quad_dac_serial_control_asserts.sv
// Concurrent checks on the ports of the quad DAC control core
`timescale 1ns/1ps

module quad_dac_serial_control_asserts
    import quad_dac_pkg::*;
#(
    parameter int NUM_CH = NUM_CHANNELS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdi,
    input wire logic select_load_n,
    input wire logic sdo,
    input wire logic sdoOe,
    input wire logic async_update_n,
    input wire logic toggle_pin,
    input wire logic clear_n,
    input wire logic overTempDetect,
    input wire logic overtemp_flag_n,
    input wire logic overtempFlagOe,
    input wire logic [2:0] span_strap_pins,
    input wire logic ref_comp_pin,
    input wire logic refDriveEnable,
    input wire logic [MUX_SEL_W-1:0] muxSel,
    input wire logic muxOutEnable,
    input wire dacOut_t [NUM_CH-1:0] chanOut
);
    logic [2:0] strapSpan;
    logic [15:0] strapCode;

    // Strap decode; straps are static after reset so the pins stand for the sample
    assign strapSpan = (span_strap_pins > SPAN_MAX) ? SPAN_0_5 : span_strap_pins;
    assign strapCode = (strapSpan >= SPAN_BIPOLAR_MIN) ? CODE_MID : CODE_ZERO;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Pin levels long enough to pass the synchronisers
    sequence s_clear_held;
        !clear_n [*6];
    endsequence
    sequence s_hot_seen;
        overTempDetect [*3];
    endsequence

    a_sdo_float: assert property (sdoOe == !select_load_n)
        else $error("sdo enable does not follow strobe");
    a_clear_code: assert property (s_clear_held |-> chanOut[0].code == strapCode)
        else $error("clear did not restore strap code");
    a_clear_ctrl: assert property (s_clear_held |-> !muxOutEnable && refDriveEnable)
        else $error("clear did not zero control state");
    a_start_strap: assert property ($fell(rst) |-> ##3 chanOut[NUM_CH-1].span == strapSpan)
        else $error("start span differs from straps");
    a_start_ref: assert property ($fell(rst) |-> ##3 refDriveEnable == ref_comp_pin)
        else $error("start reference mode wrong");
    a_hot_flag: assert property (s_hot_seen |-> ##[0:3] overtempFlagOe)
        else $error("over-temperature flag not raised");
    a_hot_hold: assert property (overtempFlagOe && !select_load_n |=> overtempFlagOe)
        else $error("flag released without strobe rise");
    a_flag_drain: assert property (overtemp_flag_n == 1'b0)
        else $error("open-drain data not low");
    a_update_all: assert property ($fell(async_update_n) && select_load_n && clear_n
        |-> ##[1:6] chanOut[0].powered && chanOut[NUM_CH-1].powered)
        else $error("async update did not power channels");
    a_mux_range: assert property (muxSel <= MUX_SEL_MAX)
        else $error("monitor source out of range");
endmodule : quad_dac_serial_control_asserts

bind quad_dac_serial_control quad_dac_serial_control_asserts #(.NUM_CH(NUM_CH)) u_asserts (
    .core_clk(core_clk), .rst(rst), .sck(sck), .sdi(sdi), .select_load_n(select_load_n),
    .sdo(sdo), .sdoOe(sdoOe), .async_update_n(async_update_n), .toggle_pin(toggle_pin),
    .clear_n(clear_n), .overTempDetect(overTempDetect), .overtemp_flag_n(overtemp_flag_n),
    .overtempFlagOe(overtempFlagOe), .span_strap_pins(span_strap_pins),
    .ref_comp_pin(ref_comp_pin), .refDriveEnable(refDriveEnable), .muxSel(muxSel),
    .muxOutEnable(muxOutEnable), .chanOut(chanOut));

//--- verification/quad_dac_serial_control_tb.sv
// Self-checking bench for the quad DAC control core
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errorCnt++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end

module quad_dac_serial_control_tb
    import quad_dac_pkg::*;
;
    logic core_clk, rst, async_update_n, toggle_pin, clear_n, overTempDetect, ref_comp_pin;
    logic [2:0] span_strap_pins;
    wire sck, sdi, select_load_n, sdoLine;
    logic sdo, sdoOe, overtemp_flag_n, overtempFlagOe, refDriveEnable, muxOutEnable;
    logic [MUX_SEL_W-1:0] muxSel;
    dacOut_t [NUM_CHANNELS-1:0] chanOut;
    int errorCnt = 0;
    int comparisons = 0;

    // Pull-up keeps the echo line high while the device floats it
    assign sdoLine = sdoOe ? sdo : 1'b1;

    quad_dac_serial_control u_dut (.core_clk(core_clk), .rst(rst), .sck(sck), .sdi(sdi),
        .select_load_n(select_load_n), .sdo(sdo), .sdoOe(sdoOe),
        .async_update_n(async_update_n), .toggle_pin(toggle_pin), .clear_n(clear_n),
        .overTempDetect(overTempDetect), .overtemp_flag_n(overtemp_flag_n),
        .overtempFlagOe(overtempFlagOe), .span_strap_pins(span_strap_pins),
        .ref_comp_pin(ref_comp_pin), .refDriveEnable(refDriveEnable), .muxSel(muxSel),
        .muxOutEnable(muxOutEnable), .chanOut(chanOut));
    host_link_model u_host (.sck(sck), .sdi(sdi), .select_load_n(select_load_n),
        .sdoLine(sdoLine));

    // Core clock, 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task summarize;
        if (errorCnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Waits whole cycles, then lets the edge's updates land before sampling
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task doReset(input logic [2:0] strap, input logic rc);
        @(posedge core_clk);
        rst <= 1'b1;
        span_strap_pins <= strap;
        ref_comp_pin <= rc;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        cyc(6);
    endtask : doReset

    // One command frame; the leading pad bits must be ignored
    task send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d, input int n);
        u_host.frame({8'hA5, c, a, d}, n);
        cyc(6);
    endtask : send

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        errorCnt++;
        summarize();
    end

    initial begin
        rst <= 1'b1;
        async_update_n <= 1'b1;
        toggle_pin <= 1'b0;
        clear_n <= 1'b1;
        overTempDetect <= 1'b0;
        span_strap_pins <= 3'h3;
        ref_comp_pin <= 1'b1;
        doReset(3'h3, 1'b1);
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            `CHK("span", 3'h3, chanOut[i].span)
            `CHK("code", CODE_MID, chanOut[i].code)
        end
        `CHK("ref", 1'b1, refDriveEnable)
        send(CMD_WRITE_N_UPDATE_N, 4'h1, 16'h1234, 32);
        `CHK("wr32", 16'h1234, chanOut[1].code)
        `CHK("sdoOe", 1'b0, sdoOe)
        send(CMD_WRITE_N_UPDATE_N, 4'h3, 16'h5A5A, 32);
        `CHK("echo", {8'hA5, CMD_WRITE_N_UPDATE_N, 4'h1, 16'h1234}, u_host.echo)
        send(CMD_WRITE_N_UPDATE_N, 4'h3, 16'h5A5A, 24);
        `CHK("wr24", 16'h5A5A, chanOut[3].code)
        send(CMD_WRITE_N_UPDATE_N, 4'h2, 16'hABCD, 28);
        `CHK("wr28", 16'hABCD, chanOut[2].code)
        // Input write alone must not move the output until the update pin falls
        send(CMD_WRITE_N, 4'h0, 16'h1111, 24);
        `CHK("noupd", CODE_MID, chanOut[0].code)
        @(posedge core_clk) async_update_n <= 1'b0;
        cyc(5);
        `CHK("upd", 16'h1111, chanOut[0].code)
        `CHK("pwr", 1'b1, chanOut[0].powered)
        @(posedge core_clk) async_update_n <= 1'b1;
        // Update pin falls mid-frame: copy waits for the strobe rise
        fork
            send(CMD_WRITE_N, 4'h0, 16'h2222, 24);
            begin
                repeat (30) @(posedge core_clk);
                async_update_n <= 1'b0;
                repeat (4) @(posedge core_clk);
                async_update_n <= 1'b1;
            end
        join
        `CHK("defer", 16'h2222, chanOut[0].code)
        @(posedge core_clk) async_update_n <= 1'b0;
        send(CMD_POWER_DOWN_N, 4'h0, 16'h0, 24);
        `CHK("pdblk", 1'b1, chanOut[0].powered)
        @(posedge core_clk) async_update_n <= 1'b1;
        send(CMD_POWER_DOWN_N, 4'h0, 16'h0, 24);
        `CHK("pd", 1'b0, chanOut[0].powered)
        send(CMD_WRITE_B_N, 4'h1, 16'hBBBB, 24);
        send(CMD_WRITE_B_N, 4'h2, 16'hB2B2, 24);
        send(CMD_WRITE_N, 4'h1, 16'hAAAA, 24);
        send(CMD_TOGGLE_SEL, 4'h0, 16'h0002, 24);
        @(posedge core_clk) toggle_pin <= 1'b1;
        cyc(5);
        `CHK("togB", 16'hBBBB, chanOut[1].code)
        `CHK("togSel", 16'hABCD, chanOut[2].code)
        @(posedge core_clk) toggle_pin <= 1'b0;
        cyc(5);
        `CHK("togA", 16'hAAAA, chanOut[1].code)
        for (int s = 0; s <= 12; s++) begin
            send(CMD_MUX, 4'h0, 16'h0020 | 16'(s), 24);
            `CHK("muxSel", 5'(s), muxSel)
        end
        `CHK("muxEn", 1'b1, muxOutEnable)
        send(CMD_MUX, 4'h0, 16'h002D, 24);
        `CHK("muxBad", MUX_SEL_MAX, muxSel)
        send(CMD_MUX, 4'h0, 16'h0003, 24);
        `CHK("muxOff", 1'b0, muxOutEnable)
        send(CMD_MUX, 4'h0, 16'h0025, 24);
        send(CMD_CONFIG, 4'h0, 16'h0001, 24);
        `CHK("refOff", 1'b0, refDriveEnable)
        send(CMD_SPAN_N, 4'h0, 16'h0002, 24);
        `CHK("spanN", SPAN_BIPOLAR_MIN, chanOut[0].span)
        send(CMD_SPAN_ALL, 4'h0, 16'h0005, 24);
        `CHK("spanBad", SPAN_BIPOLAR_MIN, chanOut[0].span)
        send(CMD_POWER_DOWN_CHIP, 4'h0, 16'h0, 24);
        `CHK("chipMux", 1'b0, muxOutEnable)
        `CHK("chipPwr", 1'b0, chanOut[1].powered)
        send(CMD_UPDATE_ALL, 4'h0, 16'h0, 24);
        `CHK("upAllMux", 1'b1, muxOutEnable)
        `CHK("upAllPwr", 1'b1, chanOut[1].powered)
        `CHK("upAllCode", 16'hAAAA, chanOut[1].code)
        @(posedge core_clk) clear_n <= 1'b0;
        cyc(6);
        for (int i = 0; i < NUM_CHANNELS; i++)
            `CHK("clrCode", CODE_MID, chanOut[i].code)
        `CHK("clrMux", 1'b0, muxOutEnable)
        `CHK("clrRef", 1'b1, refDriveEnable)
        @(posedge core_clk) clear_n <= 1'b1;
        @(posedge core_clk) overTempDetect <= 1'b1;
        repeat (5) @(posedge core_clk);
        overTempDetect <= 1'b0;
        cyc(10);
        `CHK("hot", 1'b1, overtempFlagOe)
        send(4'hF, 4'h0, 16'h0, 24);
        `CHK("hotRel", 1'b0, overtempFlagOe)
        // Second reset with grounded compensation pin and an out-of-range strap
        doReset(3'h6, 1'b0);
        `CHK("ref2", 1'b0, refDriveEnable)
        `CHK("span2", SPAN_0_5, chanOut[0].span)
        `CHK("code2", CODE_ZERO, chanOut[0].code)
        summarize();
    end
endmodule : quad_dac_serial_control_tb
